// File: ubt_top.sv
// Serial channel with an 8-bit baud generator that doubles as a timer.
// Assumes synchronous pins and a byte register port with one-cycle strobes.
//
// Contract
// - Eight data bits per character, least significant bit first, both ways.
// - Frame starts with a low start bit, ends with one or two high stops.
// - Optional parity generated on transmit and checked on receive, even or odd.
// - Control bit 4 enables parity; control bit 3 selects its sense.
// - Control bit 7 enables the transmitter; nothing is sent while clear.
// - Separate transmit and receive enables sharing one rate and format.
// - Channel keeps running during processor halt.
// - With both directions off, the baud generator acts as a timer with interrupt.
// - Baud generator is 8 bits, its count set by the rate register at F4.
// - Receive input has a noise filter switchable by software.
// - Status bit 2 reads 1 when the transmitter is enabled and its holding register is empty.
// - Byte written at F1 moves to the shift register and is sent.
// - Status bit 1 is 1 only after holding and shift registers finished.
// - Transmit and receive events raise separate interrupt requests.
// - Receiver reports framing, overrun and break conditions in status.
// - Reset: rate FF, control 00, status 02; data undefined.
// - One address: read gives last received byte, write gives next to send.
// - Control bit 6 enables receive; status bit 7 flags unread received data.
// - Framing error when the first stop bit samples 0; second never checked. A break (all bits 0) sets only the break flag; odd parity also sets parity error.
// - Overrun keeps the old byte and discards the new one.
// - Transmit-ready fires after the first bit leaves; data write clears bit 2.
`timescale 1ns/1ps
module ubt_top #(
  parameter int FIFO_DEPTH = ubt_pkg::UBT_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Serial line.
  input wire logic rx_i,
  output logic tx_o,
  // Interrupt requests.
  output logic tx_irq_o,
  output logic rx_irq_o,
  output logic timer_irq_o
);
  typedef enum logic [4:0] {
    UBT_TX_IDLE = 5'h01,
    UBT_TX_START = 5'h02,
    UBT_TX_DATA = 5'h04,
    UBT_TX_PAR = 5'h08,
    UBT_TX_STOP = 5'h10
  } ubt_tx_state_e;

  typedef enum logic [4:0] {
    UBT_RX_IDLE = 5'h01,
    UBT_RX_START = 5'h02,
    UBT_RX_DATA = 5'h04,
    UBT_RX_PAR = 5'h08,
    UBT_RX_STOP = 5'h10
  } ubt_rx_state_e;

  ubt_pkg::ubt_reg_req_s req;
  logic [7:0] ctl_r;
  logic [7:0] rate_r;
  logic [7:0] brg_cnt_r;
  logic tick;
  logic tx_en;
  logic rx_en;
  logic tx_hold_full_r;
  logic [7:0] tx_hold_r;
  ubt_tx_state_e tx_st_r;
  logic [3:0] tx_sub_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic tx_stop2_r;
  logic tx_first_r;
  logic [2:0] filt_r;
  logic rx_line;
  logic rx_prev_r;
  ubt_rx_state_e rx_st_r;
  logic [3:0] rx_sub_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_par_r;
  logic rx_all_zero_r;
  logic [7:0] rx_data_r;
  logic rx_valid_r;
  logic frame_err_r;
  logic par_err_r;
  logic overrun_r;
  logic break_r;
  logic ovr_pend_r;
  logic brk_pend_r;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic fifo_in_ready;
  logic rx_done;
  logic [7:0] rx_byte;
  logic rx_frame_bad;
  logic rx_par_bad;
  logic rx_is_break;
  logic data_rd;
  logic data_wr;

  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};
  assign tx_en = ctl_r[ubt_pkg::UBT_CTL_TX_EN];
  assign rx_en = ctl_r[ubt_pkg::UBT_CTL_RX_EN];
  assign data_rd = req.rd && (req.addr == ubt_pkg::UBT_ADDR_DATA);
  assign data_wr = req.wr && (req.addr == ubt_pkg::UBT_ADDR_DATA);

  // Control and rate registers; no halt input exists, so the channel never stops.
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctl_r <= ubt_pkg::UBT_RST_CONTROL;
      rate_r <= ubt_pkg::UBT_RST_RATE;
    end
    else if (req.wr && req.addr == ubt_pkg::UBT_ADDR_CONTROL)
    begin
      ctl_r <= req.wdata;
    end
    else if (req.wr && req.addr == ubt_pkg::UBT_ADDR_RATE)
    begin
      rate_r <= req.wdata;
    end
  end

  // Baud generator: one tick every rate+1 clocks, shared by both directions.
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      brg_cnt_r <= 8'hff;
    end
    else
    begin
      brg_cnt_r <= (brg_cnt_r == 8'h00) ? rate_r : brg_cnt_r - 8'h01;
    end
  end
  assign tick = (brg_cnt_r == 8'h00);

  // Transmit holding register; a write while full overwrites the pending byte.
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_hold_full_r <= 1'b0;
      tx_hold_r <= 8'h00;
    end
    else if (data_wr && tx_en)
    begin
      tx_hold_full_r <= 1'b1;
      tx_hold_r <= req.wdata;
    end
    else if (tx_st_r == UBT_TX_IDLE && tx_hold_full_r && tick)
    begin
      tx_hold_full_r <= 1'b0;
    end
  end

  // Transmit shifter; the line idles high and each bit lasts sixteen ticks.
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_st_r <= UBT_TX_IDLE;
      tx_sub_r <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_stop2_r <= 1'b0;
      tx_o <= 1'b1;
      tx_first_r <= 1'b0;
    end
    else if (!tx_en)
    begin
      tx_st_r <= UBT_TX_IDLE;
      tx_o <= 1'b1;
      tx_first_r <= 1'b0;
    end
    else if (tick)
    begin
      tx_first_r <= 1'b0;
      tx_sub_r <= tx_sub_r + 4'h1;
      case (tx_st_r)
        UBT_TX_IDLE:
        begin
          if (tx_hold_full_r)
          begin
            tx_sh_r <= tx_hold_r;
            tx_st_r <= UBT_TX_START;
            tx_sub_r <= 4'h0;
            tx_o <= 1'b0;
          end
        end
        UBT_TX_START:
        begin
          if (tx_sub_r == ubt_pkg::UBT_LAST_TICK)
          begin
            tx_st_r <= UBT_TX_DATA;
            tx_bit_r <= 3'h0;
            tx_o <= tx_sh_r[0];
            tx_first_r <= 1'b1;
          end
        end
        UBT_TX_DATA:
        begin
          if (tx_sub_r == ubt_pkg::UBT_LAST_TICK)
          begin
            if (tx_bit_r == 3'h7)
            begin
              if (ctl_r[ubt_pkg::UBT_CTL_PAR_EN])
              begin
                tx_st_r <= UBT_TX_PAR;
                tx_o <= ^tx_sh_r ^ ctl_r[ubt_pkg::UBT_CTL_PAR_ODD];
              end
              else
              begin
                tx_st_r <= UBT_TX_STOP;
                tx_o <= 1'b1;
              end
              tx_stop2_r <= ctl_r[ubt_pkg::UBT_CTL_TWO_STOP];
            end
            else
            begin
              tx_bit_r <= tx_bit_r + 3'h1;
              tx_o <= tx_sh_r[tx_bit_r + 3'h1];
            end
          end
        end
        UBT_TX_PAR:
        begin
          if (tx_sub_r == ubt_pkg::UBT_LAST_TICK)
          begin
            tx_st_r <= UBT_TX_STOP;
            tx_o <= 1'b1;
          end
        end
        UBT_TX_STOP:
        begin
          if (tx_sub_r == ubt_pkg::UBT_LAST_TICK)
          begin
            if (tx_stop2_r)
            begin
              tx_stop2_r <= 1'b0;
            end
            else
            begin
              tx_st_r <= UBT_TX_IDLE;
            end
          end
        end
        default:
        begin
          tx_st_r <= UBT_TX_IDLE;
        end
      endcase
    end
  end

  // Noise filter: majority of three registered samples when enabled, the newest registered sample alone otherwise.
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      filt_r <= 3'h7;
      rx_prev_r <= 1'b1;
    end
    else
    begin
      filt_r <= {filt_r[1:0], rx_i};
      rx_prev_r <= rx_line;
    end
  end
  assign rx_line = ctl_r[ubt_pkg::UBT_CTL_FILT_EN] ?
                   ((filt_r[0] & filt_r[1]) | (filt_r[1] & filt_r[2]) | (filt_r[0] & filt_r[2]))
                   : filt_r[0];

  // Receive sampler: a falling edge restarts timing, bits taken at mid-bit.
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_st_r <= UBT_RX_IDLE;
      rx_sub_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_par_r <= 1'b0;
      rx_all_zero_r <= 1'b0;
    end
    else if (!rx_en)
    begin
      rx_st_r <= UBT_RX_IDLE;
    end
    else if (rx_st_r == UBT_RX_IDLE)
    begin
      if (rx_prev_r && !rx_line)
      begin
        rx_st_r <= UBT_RX_START;
        rx_sub_r <= 4'h0;
      end
    end
    else if (tick)
    begin
      rx_sub_r <= rx_sub_r + 4'h1;
      if (rx_sub_r == ubt_pkg::UBT_MID_TICK)
      begin
        case (rx_st_r)
          UBT_RX_START:
          begin
            rx_st_r <= rx_line ? UBT_RX_IDLE : UBT_RX_DATA;
            rx_bit_r <= 3'h0;
            rx_all_zero_r <= 1'b1;
          end
          UBT_RX_DATA:
          begin
            rx_sh_r <= {rx_line, rx_sh_r[7:1]};
            rx_all_zero_r <= rx_all_zero_r & ~rx_line;
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == 3'h7)
            begin
              rx_st_r <= ctl_r[ubt_pkg::UBT_CTL_PAR_EN] ? UBT_RX_PAR : UBT_RX_STOP;
            end
          end
          UBT_RX_PAR:
          begin
            rx_par_r <= rx_line;
            rx_all_zero_r <= rx_all_zero_r & ~rx_line;
            rx_st_r <= UBT_RX_STOP;
          end
          UBT_RX_STOP:
          begin
            rx_st_r <= UBT_RX_IDLE;
          end
          default:
          begin
            rx_st_r <= UBT_RX_IDLE;
          end
        endcase
      end
    end
  end

  // Character end is the mid-point of the first stop bit.
  assign rx_done = rx_en && tick && rx_st_r == UBT_RX_STOP && rx_sub_r == ubt_pkg::UBT_MID_TICK;
  assign rx_frame_bad = !rx_line;
  assign rx_is_break = rx_all_zero_r && !rx_line;
  assign rx_par_bad = ctl_r[ubt_pkg::UBT_CTL_PAR_EN] &&
                      (rx_par_r != (^rx_sh_r ^ ctl_r[ubt_pkg::UBT_CTL_PAR_ODD]));

  // Received characters queue here so the data register sees them in order.
  ubt_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(rx_done && !rx_is_break),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rx_sh_r),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );
  assign rx_byte = fifo_out_data;
  assign fifo_out_ready = !rx_valid_r || data_rd;

  // Receive data register and error flags; set wins over a clearing read.
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_data_r <= 8'h00;
      rx_valid_r <= 1'b0;
      frame_err_r <= 1'b0;
      par_err_r <= 1'b0;
      overrun_r <= 1'b0;
      break_r <= 1'b0;
      ovr_pend_r <= 1'b0;
      brk_pend_r <= 1'b0;
    end
    else
    begin
      if (fifo_out_valid && fifo_out_ready)
      begin
        rx_data_r <= rx_byte;
        rx_valid_r <= 1'b1;
      end
      else if (data_rd)
      begin
        rx_valid_r <= 1'b0;
      end
      if (data_rd)
      begin
        frame_err_r <= 1'b0;
        par_err_r <= 1'b0;
        overrun_r <= ovr_pend_r;
        break_r <= brk_pend_r;
        ovr_pend_r <= 1'b0;
        brk_pend_r <= 1'b0;
      end
      // A clearing read in the same cycle drops the old flag but never the new event.
      if (rx_done)
      begin
        frame_err_r <= (frame_err_r & ~data_rd) | (rx_frame_bad & ~rx_is_break);
        par_err_r <= (par_err_r & ~data_rd) | rx_par_bad;
        if (rx_is_break)
        begin
          if (rx_valid_r && !data_rd)
          begin
            brk_pend_r <= 1'b1;
          end
          else
          begin
            break_r <= 1'b1;
          end
        end
        else if (!fifo_in_ready)
        begin
          ovr_pend_r <= 1'b1;
        end
      end
    end
  end

  // Register read mux; registered so the read data stands from a flip-flop.
  // A disabled transmitter drops written bytes, so the holder only reads empty while enabled.
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else
    begin
      case (req.addr)
        ubt_pkg::UBT_ADDR_DATA: reg_rdata_o <= rx_data_r;
        ubt_pkg::UBT_ADDR_STATUS: reg_rdata_o <= {rx_valid_r, frame_err_r, par_err_r,
          overrun_r, break_r, tx_en && !tx_hold_full_r,
          !tx_hold_full_r && tx_st_r == UBT_TX_IDLE, 1'b0};
        ubt_pkg::UBT_ADDR_CONTROL: reg_rdata_o <= ctl_r;
        ubt_pkg::UBT_ADDR_RATE: reg_rdata_o <= rate_r;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Transmit and receive requests as levels; the timer request is a one-clock pulse per tick.
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
      timer_irq_o <= 1'b0;
    end
    else
    begin
      // A data write beats the idle level, or it could never clear the request.
      if (tx_first_r)
      begin
        tx_irq_o <= 1'b1;
      end
      else if (data_wr || !tx_en)
      begin
        tx_irq_o <= 1'b0;
      end
      else if (!tx_hold_full_r && tx_st_r == UBT_TX_IDLE)
      begin
        tx_irq_o <= 1'b1;
      end
      rx_irq_o <= rx_valid_r | frame_err_r | par_err_r | overrun_r | break_r;
      timer_irq_o <= !tx_en && !rx_en && tick;
    end
  end
endmodule

// File: ubt_pkg.sv
// Package for the serial channel with baud timer: register map, fields, reset values.
// Assumes a byte-wide register port with single-cycle read and write strobes.
package ubt_pkg;

  // Register offsets in the control register space.
  localparam logic [7:0] UBT_ADDR_DATA = 8'hf1;
  localparam logic [7:0] UBT_ADDR_STATUS = 8'hf2;
  localparam logic [7:0] UBT_ADDR_CONTROL = 8'hf3;
  localparam logic [7:0] UBT_ADDR_RATE = 8'hf4;

  // Reset values.
  localparam logic [7:0] UBT_RST_STATUS = 8'h02;
  localparam logic [7:0] UBT_RST_CONTROL = 8'h00;
  localparam logic [7:0] UBT_RST_RATE = 8'hff;

  // Control register field positions.
  localparam int UBT_CTL_TX_EN = 7;
  localparam int UBT_CTL_RX_EN = 6;
  localparam int UBT_CTL_FILT_EN = 5;
  localparam int UBT_CTL_PAR_EN = 4;
  localparam int UBT_CTL_PAR_ODD = 3;
  localparam int UBT_CTL_TWO_STOP = 2;

  // Status register field positions.
  localparam int UBT_ST_RX_VALID = 7;
  localparam int UBT_ST_FRAME_ERR = 6;
  localparam int UBT_ST_PAR_ERR = 5;
  localparam int UBT_ST_OVERRUN = 4;
  localparam int UBT_ST_BREAK = 3;
  localparam int UBT_ST_TX_EMPTY = 2;
  localparam int UBT_ST_TX_DONE = 1;

  // Timing: sixteen sub-bit ticks per bit, sample in the middle.
  localparam int UBT_OVERSAMPLE = 16;
  localparam logic [3:0] UBT_MID_TICK = 4'h7;
  localparam logic [3:0] UBT_LAST_TICK = 4'hf;
  localparam int UBT_DATA_BITS = 8;
  localparam int UBT_FIFO_DEPTH = 8;

  // Register read and write request travelling together.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ubt_reg_req_s;

endpackage

// File: ubt_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module ubt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Filling side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Draining side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_o = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem[rptr_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage has no reset; only the pointers and the count need a defined value.
  always_ff @(posedge ref_clk_i)
  begin
    if (push)
    begin
      mem[wptr_r] <= in_data_i;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop)
      begin
        rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: ubt_top_properties.sv
// Concurrent checks on the serial channel, seeing only the top module's ports.
// Assumes it is bound to ubt_top and shares its single clock and reset.
`timescale 1ns/1ps
module ubt_chk (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // Serial line and requests.
  input wire logic rx_i,
  input wire logic tx_o,
  input wire logic tx_irq_o,
  input wire logic rx_irq_o,
  input wire logic timer_irq_o
);
  logic [7:0] ctl_r;
  logic [7:0] rate_r;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Shadow copies of control and rate, so timing can be judged from the port traffic.
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctl_r <= ubt_pkg::UBT_RST_CONTROL;
      rate_r <= ubt_pkg::UBT_RST_RATE;
    end
    else if (reg_wr_i && reg_addr_i == ubt_pkg::UBT_ADDR_CONTROL)
      ctl_r <= reg_wdata_i;
    else if (reg_wr_i && reg_addr_i == ubt_pkg::UBT_ADDR_RATE)
      rate_r <= reg_wdata_i;
  end
  a_unmapped_reads_zero: assert property ((reg_addr_i < 8'hf1 || reg_addr_i > 8'hf4)
    |=> reg_rdata_o == 8'h00) else $error("unmapped address returned data");
  a_rate_reads_back: assert property (reg_addr_i == ubt_pkg::UBT_ADDR_RATE
    |=> reg_rdata_o == $past(rate_r)) else $error("rate register read back wrong");
  a_ctl_reads_back: assert property (reg_addr_i == ubt_pkg::UBT_ADDR_CONTROL
    |=> reg_rdata_o == $past(ctl_r)) else $error("control register read back wrong");
  a_timer_needs_idle: assert property (timer_irq_o |-> $past(ctl_r[7:6]) == 2'b00
    || $past(ctl_r[7:6], 2) == 2'b00) else $error("timer pulse while channel enabled");
  a_timer_tick_period: assert property (timer_irq_o && rate_r == 8'h01 |=> !timer_irq_o
    ##1 (timer_irq_o || ctl_r[7:6] != 2'b00 || rate_r != 8'h01)) else $error("timer period");
  a_low_bit_width: assert property ($fell(tx_o) |-> !tx_o [*8])
    else $error("low serial bit too short");
  a_high_bit_width: assert property ($rose(tx_o) |=> $stable(tx_o) [*7])
    else $error("high serial bit too short");
  a_start_needs_enable: assert property ($fell(tx_o) |-> $past(ctl_r[7]))
    else $error("line went low with transmitter off");
  a_write_clears_ready: assert property (reg_wr_i && reg_addr_i == ubt_pkg::UBT_ADDR_DATA
    && ctl_r[7] |=> !tx_irq_o) else $error("data write left transmit request up");
endmodule

// File: ubt_peer.sv
// Far-end station on the serial line: sends frames and decodes what it hears.
// Assumes the bench sets the bit length in clocks and the expected frame format.
`timescale 1ns/1ps
module ubt_peer #(
  parameter int BIT_CLKS = 32
) (
  // Clock.
  input wire logic ref_clk_i,
  // Serial line.
  input wire logic line_i,
  output logic line_o,
  // Expected frame format.
  input wire logic par_en_i,
  input wire logic two_stop_i,
  // Last decoded character.
  output logic [7:0] got_data_o,
  output logic got_par_o,
  output logic [1:0] got_stop_o,
  output logic [7:0] got_cnt_o
);
  // The line idles high, so the receiver never sees a false start.
  initial
  begin
    line_o = 1'b1;
    got_cnt_o = 8'h00;
  end
  // Shifts a frame out least significant bit first, then returns the line high.
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge ref_clk_i);
      line_o <= bits[i];
      repeat (BIT_CLKS - 1) @(posedge ref_clk_i);
    end
    @(posedge ref_clk_i);
    line_o <= 1'b1;
  endtask
  // Samples each bit in its middle, timed from the falling edge of the start bit.
  always
  begin
    @(negedge line_i);
    repeat (BIT_CLKS / 2) @(posedge ref_clk_i);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CLKS) @(posedge ref_clk_i);
      got_data_o[i] = line_i;
    end
    if (par_en_i)
    begin
      repeat (BIT_CLKS) @(posedge ref_clk_i);
      got_par_o = line_i;
    end
    repeat (BIT_CLKS) @(posedge ref_clk_i);
    got_stop_o = {1'b1, line_i};
    if (two_stop_i)
    begin
      repeat (BIT_CLKS) @(posedge ref_clk_i);
      got_stop_o[1] = line_i;
    end
    got_cnt_o = got_cnt_o + 8'h01;
  end
endmodule

// File: ubt_top_bench.sv
// Bench for the serial channel: register tasks, a far-end station and checks.
// Assumes the package, design, checker and peer files are compiled first.
`timescale 1ns/1ps
module ubt_top_bench;
  localparam int BC = 32;
  localparam logic [7:0] A_DAT = ubt_pkg::UBT_ADDR_DATA;
  localparam logic [7:0] A_ST = ubt_pkg::UBT_ADDR_STATUS;
  localparam logic [7:0] A_CTL = ubt_pkg::UBT_ADDR_CONTROL;
  localparam logic [7:0] A_RATE = ubt_pkg::UBT_ADDR_RATE;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic rx_line;
  logic tx_line;
  logic tx_irq;
  logic rx_irq;
  logic timer_irq;
  logic par_en = 1'b0;
  logic two_stop = 1'b0;
  logic [7:0] got_data;
  logic got_par;
  logic [1:0] got_stop;
  logic [7:0] got_cnt;
  int n_errors = 0;
  int cmp_count = 0;
  int n_tick = 0;
  int n_cyc = 0;
  ubt_top #(.FIFO_DEPTH(8)) dut_u (.ref_clk_i(ref_clk), .rst_i(rst), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .rx_i(rx_line), .tx_o(tx_line), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq),
    .timer_irq_o(timer_irq));
  ubt_peer #(.BIT_CLKS(BC)) peer_u (.ref_clk_i(ref_clk), .line_i(tx_line), .line_o(rx_line),
    .par_en_i(par_en), .two_stop_i(two_stop), .got_data_o(got_data), .got_par_o(got_par),
    .got_stop_o(got_stop), .got_cnt_o(got_cnt));
  // Free-running 200 MHz clock.
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Counts timer pulses and cuts a hung run short well after the tests should end.
  always @(posedge ref_clk)
  begin
    n_cyc <= n_cyc + 1;
    if (timer_irq === 1'b1)
      n_tick <= n_tick + 1;
    if (n_cyc == 40000)
    begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Writes hold their strobe for one edge; the trailing delay lets registered outputs settle.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_st(input int b, input logic v);
    logic [7:0] s;
    s = ~{8{v}};
    for (int n = 0; n < 3000 && s[b] !== v; n++)
      rd_reg(A_ST, s);
    check({7'h00, s[b]}, {7'h00, v});
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence of register calls and line traffic, each with its expected value.
  initial
  begin
    logic [7:0] d;
    logic [7:0] x;
    logic [7:0] c;
    logic [7:0] cfg [4];
    logic [31:0] rxt [4];
    cfg = '{8'h80, 8'h90, 8'h98, 8'h84};
    rxt = '{32'h3c01f880, 32'h81032020, 32'h5a004040, 32'h00000808};
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(A_ST, d);
    check(d, ubt_pkg::UBT_RST_STATUS);
    rd_reg(A_CTL, d);
    check(d, ubt_pkg::UBT_RST_CONTROL);
    rd_reg(A_RATE, d);
    check(d, ubt_pkg::UBT_RST_RATE);
    rd_reg(8'hf5, d);
    check(d, 8'h00);
    wr_reg(A_RATE, 8'h01);
    rd_reg(A_RATE, d);
    check(d, 8'h01);
    // The generator reloads only when its old count runs out, so let that happen first.
    repeat (300) @(posedge ref_clk);
    c = 8'(n_tick);
    repeat (64) @(posedge ref_clk);
    check(8'(n_tick) - c, 8'h20);
    wr_reg(A_CTL, 8'h40);
    repeat (4) @(posedge ref_clk);
    c = 8'(n_tick);
    repeat (64) @(posedge ref_clk);
    check(8'(n_tick) - c, 8'h00);
    c = got_cnt;
    wr_reg(A_DAT, 8'h55);
    repeat (12 * BC) @(posedge ref_clk);
    check(got_cnt, c);
    foreach (cfg[i])
    begin
      par_en <= cfg[i][4];
      two_stop <= cfg[i][2];
      wr_reg(A_CTL, cfg[i]);
      // The request follows the new enable one edge after the write lands.
      repeat (2) @(posedge ref_clk);
      check({6'h00, tx_irq, rx_irq}, 8'h02);
      x = 8'h96 + 8'(i) * 8'h25;
      c = got_cnt;
      wr_reg(A_DAT, x);
      wait_st(ubt_pkg::UBT_ST_TX_DONE, 1'b1);
      check(got_cnt - c, 8'h01);
      check(got_data, x);
      check({6'h00, got_stop}, 8'h03);
      if (cfg[i][4])
        check({7'h00, got_par}, {7'h00, ^x ^ cfg[i][3]});
    end
    c = got_cnt;
    wr_reg(A_DAT, 8'h3e);
    wait_st(ubt_pkg::UBT_ST_TX_EMPTY, 1'b1);
    wr_reg(A_DAT, 8'hc1);
    rd_reg(A_ST, d);
    check(d & 8'h06, 8'h00);
    wait_st(ubt_pkg::UBT_ST_TX_DONE, 1'b1);
    check(got_cnt - c, 8'h02);
    check(got_data, 8'hc1);
    wr_reg(A_CTL, 8'h70);
    foreach (rxt[i])
    begin
      x = rxt[i][31:24];
      peer_u.send({rxt[i][16], ^x ^ rxt[i][17], x, 1'b0}, 11);
      for (int k = 0; k < 400 && rx_irq !== 1'b1; k++)
        @(posedge ref_clk);
      rd_reg(A_ST, d);
      check(d & rxt[i][15:8], rxt[i][7:0]);
      rd_reg(A_DAT, d);
      if (rxt[i][7])
        check(d, x);
    end
    for (int k = 0; k < 10; k++)
      peer_u.send({1'b1, ^(8'h10 + 8'(k)), 8'h10 + 8'(k), 1'b0}, 11);
    for (int k = 0; k < 9; k++)
    begin
      rd_reg(A_DAT, d);
      check(d, 8'h10 + 8'(k));
      if (k == 0)
      begin
        rd_reg(A_ST, d);
        check(d & 8'h10, 8'h10);
      end
    end
    rd_reg(A_ST, d);
    check(d & 8'h80, 8'h00);
    complete_run();
  end
endmodule
bind ubt_top ubt_chk chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .rx_i(rx_i), .tx_o(tx_o), .tx_irq_o(tx_irq_o),
  .rx_irq_o(rx_irq_o), .timer_irq_o(timer_irq_o));
